// ---- design/data_eeprom_access_ctrl.sv ----
// Purpose: register front end and sequencer for the data nonvolatile byte store
// Assumes: cpu special function port, control register only in bank 1
// Notes: write length counted in synchronised auxiliary clock ticks
`timescale 1ns/1ns
module data_eeprom_access_ctrl (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata_r,
   input  wire logic       low_speed_aux_clock,
   input  wire logic       irq_ack,
   output logic            irq_req_r
);
   nv_pkg::state_t                  state_r;
   nv_pkg::ctrl_t                   ctrl_r;
   nv_pkg::irq_t                    irq_r;
   logic                            bank_select_r;
   logic [7:0]                      indirect_ptr_one_r;
   logic [nv_pkg::CELL_BITS-1:0]    nv_cell_index_r;
   logic [7:0]                      nv_byte_buf_r;
   logic [7:0]                      tick_cnt_r;
   logic [1:0]                      read_cnt_r;
   logic [7:0]                      eff_addr;
   logic                            bank0_hit;
   logic                            wr_ctrl;
   logic                            wr_buf;
   logic                            wr_irq;
   logic                            start_wr;
   logic                            start_rd;
   logic                            write_done;
   logic                            read_done;
   logic                            aux_tick;
   logic [7:0]                      mem_rdata;
   logic [7:0]                      rd_mux;

   // indirect port resolves through the pointer
   assign eff_addr  = (sfr_addr == nv_pkg::ADDR_IND_PORT) ? indirect_ptr_one_r : sfr_addr;
   assign bank0_hit = (bank_select_r != nv_pkg::BANK_CTRL);
   // control register visible only in bank 1
   assign wr_ctrl   = sfr_wr && (bank_select_r == nv_pkg::BANK_CTRL) && (eff_addr == nv_pkg::ADDR_NV_CTRL);
   assign wr_buf    = sfr_wr && bank0_hit && (eff_addr == nv_pkg::ADDR_BYTE_BUF);
   assign wr_irq    = sfr_wr && bank0_hit && (eff_addr == nv_pkg::ADDR_IRQ);

   // go bits judged against the allow bits already held
   assign start_wr  = wr_ctrl && sfr_wdata[nv_pkg::BIT_WRITE_GO]
                      && ctrl_r.program_allow && (state_r == nv_pkg::ST_IDLE);
   assign start_rd  = wr_ctrl && sfr_wdata[nv_pkg::BIT_READ_GO] && !start_wr
                      && ctrl_r.fetch_allow && (state_r == nv_pkg::ST_IDLE);
   assign write_done = (state_r == nv_pkg::ST_WRITE) && aux_tick && (tick_cnt_r == nv_pkg::WRITE_LAST);
   assign read_done  = (state_r == nv_pkg::ST_READ) && (read_cnt_r == nv_pkg::READ_LAST);

   // timer edges arrive with no fixed relation to clk
   aux_tick_sync u_sync (
      .clk    (clk),
      .rst    (rst),
      .aux_in (low_speed_aux_clock),
      .tick   (aux_tick)
   );

   nv_cell_array u_cells (
      .clk   (clk),
      .rst   (rst),
      .wr_en (write_done),
      .rd_en (start_rd),
      .addr  (nv_cell_index_r),
      .wdata (nv_byte_buf_r),
      .rdata (mem_rdata)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= nv_pkg::ST_IDLE;
      end else begin
         case (state_r)
            nv_pkg::ST_IDLE: begin
               if (start_wr) begin
                  state_r <= nv_pkg::ST_WRITE;
               end else if (start_rd) begin
                  state_r <= nv_pkg::ST_READ;
               end
            end
            nv_pkg::ST_READ: begin
               if (read_done) begin
                  state_r <= nv_pkg::ST_IDLE;
               end
            end
            nv_pkg::ST_WRITE: begin
               if (write_done) begin
                  state_r <= nv_pkg::ST_IDLE;
               end
            end
            default: begin
               state_r <= nv_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_r != nv_pkg::ST_WRITE) begin
         tick_cnt_r <= nv_pkg::RST_BYTE;
      end else if (aux_tick) begin
         tick_cnt_r <= tick_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_r != nv_pkg::ST_READ) begin
         read_cnt_r <= 2'h0;
      end else begin
         read_cnt_r <= read_cnt_r + 2'h1;
      end
   end

   // control register; go bits cleared only by hardware
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_r.program_allow <= sfr_wdata[nv_pkg::BIT_PROGRAM_ALLOW];
            ctrl_r.fetch_allow   <= sfr_wdata[nv_pkg::BIT_FETCH_ALLOW];
         end
         if (start_wr) begin
            ctrl_r.write_go <= 1'b1;
         end else if (write_done) begin
            ctrl_r.write_go <= 1'b0;
         end
         if (start_rd) begin
            ctrl_r.read_go <= 1'b1;
         end else if (read_done) begin
            ctrl_r.read_go <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bank_select_r      <= 1'b0;
         indirect_ptr_one_r <= nv_pkg::RST_BYTE;
         nv_cell_index_r    <= nv_pkg::RST_INDEX;
      end else if (sfr_wr) begin
         if (sfr_addr == nv_pkg::ADDR_BANK) begin
            bank_select_r <= sfr_wdata[nv_pkg::BIT_BANK_SEL];
         end
         if (sfr_addr == nv_pkg::ADDR_IND_PTR) begin
            indirect_ptr_one_r <= sfr_wdata;
         end
         if (bank0_hit && eff_addr == nv_pkg::ADDR_CELL_INDEX) begin
            nv_cell_index_r <= sfr_wdata[nv_pkg::CELL_BITS-1:0];
         end
      end
   end

   // fetched byte stays until a later fetch or a store
   always_ff @(posedge clk) begin
      if (rst) begin
         nv_byte_buf_r <= nv_pkg::RST_BYTE;
      end else if (read_done) begin
         nv_byte_buf_r <= mem_rdata;
      end else if (wr_buf) begin
         nv_byte_buf_r <= sfr_wdata;
      end
   end

   // hardware set wins over any clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_r <= '0;
      end else begin
         if (wr_irq) begin
            irq_r.global_allow <= sfr_wdata[nv_pkg::BIT_GLOBAL_ALLOW];
            irq_r.mf_allow     <= sfr_wdata[nv_pkg::BIT_MF_ALLOW];
            irq_r.done_allow   <= sfr_wdata[nv_pkg::BIT_DONE_ALLOW];
         end
         if (write_done) begin
            irq_r.done_flag <= 1'b1;
            irq_r.mf_flag   <= 1'b1;
         end else begin
            if (wr_irq) begin
               irq_r.done_flag <= sfr_wdata[nv_pkg::BIT_DONE_FLAG];
            end
            if (irq_ack) begin
               irq_r.mf_flag <= 1'b0;
            end else if (wr_irq) begin
               irq_r.mf_flag <= sfr_wdata[nv_pkg::BIT_MF_FLAG];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_req_r <= 1'b0;
      end else begin
         irq_req_r <= irq_r.mf_flag && irq_r.mf_allow && irq_r.done_allow && irq_r.global_allow;
      end
   end

   always_comb begin
      rd_mux = nv_pkg::RST_BYTE;
      if (sfr_addr == nv_pkg::ADDR_BANK) begin
         rd_mux = {7'h00, bank_select_r};
      end else if (sfr_addr == nv_pkg::ADDR_IND_PTR) begin
         rd_mux = indirect_ptr_one_r;
      end else if (!bank0_hit) begin
         if (eff_addr == nv_pkg::ADDR_NV_CTRL) begin
            rd_mux = {4'h0, ctrl_r};
         end
      end else if (eff_addr == nv_pkg::ADDR_CELL_INDEX) begin
         rd_mux = {3'h0, nv_cell_index_r};
      end else if (eff_addr == nv_pkg::ADDR_BYTE_BUF) begin
         rd_mux = nv_byte_buf_r;
      end else if (eff_addr == nv_pkg::ADDR_IRQ) begin
         rd_mux = {3'h0, irq_r};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sfr_rdata_r <= nv_pkg::RST_BYTE;
      end else begin
         sfr_rdata_r <= sfr_rd ? rd_mux : nv_pkg::RST_BYTE;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence seq_idle_ctrl_write;
      wr_ctrl && (state_r == nv_pkg::ST_IDLE);
   endsequence

   sequence seq_write_request;
      seq_idle_ctrl_write ##0 sfr_wdata[nv_pkg::BIT_WRITE_GO];
   endsequence

   sequence seq_read_request;
      seq_idle_ctrl_write ##0 sfr_wdata[nv_pkg::BIT_READ_GO] && !sfr_wdata[nv_pkg::BIT_WRITE_GO];
   endsequence

   a_write_start: assert property (seq_write_request ##0 ctrl_r.program_allow
      |=> state_r == nv_pkg::ST_WRITE && ctrl_r.write_go) else $error("write did not start");
   a_write_lock: assert property (seq_write_request ##0 !ctrl_r.program_allow
      |=> !ctrl_r.write_go && state_r == nv_pkg::ST_IDLE) else $error("write started unallowed");
   a_read_start: assert property (seq_read_request ##0 ctrl_r.fetch_allow
      |=> ctrl_r.read_go ##2 !ctrl_r.read_go) else $error("read go not cleared in time");
   a_read_lock: assert property (seq_read_request ##0 !ctrl_r.fetch_allow
      |=> !ctrl_r.read_go && state_r == nv_pkg::ST_IDLE) else $error("read started unallowed");
   a_read_loads: assert property (read_done |=> nv_byte_buf_r == $past(mem_rdata)) else $error("read byte lost");
   a_write_end: assert property ($fell(ctrl_r.write_go) |-> irq_r.done_flag && irq_r.mf_flag
      && $past(tick_cnt_r) == nv_pkg::WRITE_LAST) else $error("write end flags wrong");
   a_irq_gate: assert property (irq_req_r |-> $past(irq_r.mf_flag && irq_r.mf_allow
      && irq_r.done_allow && irq_r.global_allow)) else $error("irq without enables");
   a_ack_clear: assert property (irq_ack && !write_done |=> !irq_r.mf_flag
      && (irq_r.done_flag == $past(irq_r.done_flag) || $past(wr_irq))) else $error("ack clear wrong");
   a_buf_hold: assert property (state_r == nv_pkg::ST_IDLE && !wr_buf
      |=> $stable(nv_byte_buf_r)) else $error("buffer changed while idle");
   a_reset_prot: assert property ($past(rst) |-> !ctrl_r.program_allow && !bank_select_r)
      else $error("protection not reset");
endmodule

// ---- design/nv_pkg.sv ----
// Purpose: shared constants and types for the data nonvolatile byte store
// Assumes: 8-bit special function register port, banked addressing
// Notes: bank-0 offsets other than the control register are local picks
package nv_pkg;
   // register map, special function address space
   localparam logic [7:0] ADDR_IND_PORT   = 8'h02;
   localparam logic [7:0] ADDR_IND_PTR    = 8'h03;
   localparam logic [7:0] ADDR_BANK       = 8'h04;
   localparam logic [7:0] ADDR_CELL_INDEX = 8'h0a;
   localparam logic [7:0] ADDR_BYTE_BUF   = 8'h0b;
   localparam logic [7:0] ADDR_IRQ        = 8'h0c;
   localparam logic [7:0] ADDR_NV_CTRL    = 8'h40;
   localparam logic       BANK_CTRL       = 1'b1;
   localparam int         BIT_BANK_SEL    = 0;

   // control register fields
   localparam int BIT_READ_GO       = 0;
   localparam int BIT_FETCH_ALLOW   = 1;
   localparam int BIT_WRITE_GO      = 2;
   localparam int BIT_PROGRAM_ALLOW = 3;

   // interrupt register fields
   localparam int BIT_GLOBAL_ALLOW = 0;
   localparam int BIT_MF_ALLOW     = 1;
   localparam int BIT_DONE_ALLOW   = 2;
   localparam int BIT_MF_FLAG      = 3;
   localparam int BIT_DONE_FLAG    = 4;

   // array geometry
   localparam int CELL_BITS = 5;
   localparam int CELLS     = 32;

   // reset values
   localparam logic [7:0]           RST_BYTE  = 8'h00;
   localparam logic [CELL_BITS-1:0] RST_INDEX = 5'h00;

   // timing
   localparam int         CLK_PERIOD_NS   = 8;
   localparam int         READ_TIME_NS    = 16;
   localparam int         READ_CYCLES     = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] READ_LAST       = 2'(READ_CYCLES - 1);
   localparam logic [7:0] WRITE_AUX_TICKS = 8'h40;
   localparam logic [7:0] WRITE_LAST      = WRITE_AUX_TICKS - 8'h01;

   typedef struct packed {
      logic program_allow;
      logic write_go;
      logic fetch_allow;
      logic read_go;
   } ctrl_t;

   typedef struct packed {
      logic done_flag;
      logic mf_flag;
      logic done_allow;
      logic mf_allow;
      logic global_allow;
   } irq_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } state_t;
endpackage

// ---- design/aux_tick_sync.sv ----
// Purpose: bring the slow auxiliary clock into clk and mark its rising edges
// Assumes: aux clock far slower than clk
// Notes: tick is one clk cycle wide
`timescale 1ns/1ns
module aux_tick_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic aux_in,
   output logic      tick
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= aux_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // edge taken only behind the second stage
   assign tick = sync_r & ~prev_r;
endmodule

// ---- design/nv_cell_array.sv ----
// Purpose: byte-wide storage cells
// Assumes: one access per cycle
// Notes: cells keep their content across reset, as a nonvolatile store would
`timescale 1ns/1ns
module nv_cell_array (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic                            wr_en,
   input  wire logic                            rd_en,
   input  wire logic [nv_pkg::CELL_BITS-1:0]    addr,
   input  wire logic [7:0]                      wdata,
   output logic      [7:0]                      rdata
);
   logic [7:0] cells [nv_pkg::CELLS];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         cells[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= nv_pkg::RST_BYTE;
      end else if (rd_en) begin
         rdata <= cells[addr];
      end
   end
endmodule

// ---- bench/data_eeprom_access_ctrl_bench.sv ----
// Purpose: self-checking bench for the data nonvolatile byte store control
// Assumes: bank select reachable from both banks, control reg at 0x40 in bank 1
// Notes: aux clock period is ten clk periods, at a fixed phase to clk; model keeps cells in an int array
`timescale 1ns/1ns
module data_eeprom_access_ctrl_bench;
   logic       clk;
   logic       rst;
   logic [7:0] sfr_addr;
   logic       sfr_wr;
   logic       sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata_r;
   logic       low_speed_aux_clock;
   logic       irq_ack;
   logic       irq_req_r;
   int         err_count;
   int         num_checks;
   int         mem [32];
   int         a_q [$];

   data_eeprom_access_ctrl i_dut (
      .clk                 (clk),
      .rst                 (rst),
      .sfr_addr            (sfr_addr),
      .sfr_wr              (sfr_wr),
      .sfr_rd              (sfr_rd),
      .sfr_wdata           (sfr_wdata),
      .sfr_rdata_r         (sfr_rdata_r),
      .low_speed_aux_clock (low_speed_aux_clock),
      .irq_ack             (irq_ack),
      .irq_req_r           (irq_req_r)
   );

   initial clk = 1'b0;
   always #4 clk = ~clk;

   // aux clock stable and running before any write, odd offset puts every edge 1 ns before a clk rising edge
   initial begin
      low_speed_aux_clock = 1'b0;
      #3;
      forever #40 low_speed_aux_clock = ~low_speed_aux_clock;
   end

   task automatic end_sim;
      $display("checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: register read %h, model %h", $time, got, exp);
      end
   endtask

   task automatic chk_irq(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: irq request %b, model %b", $time, got, exp);
      end
   endtask

   // gap cycle after each strobe so a strobe is never assigned twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(posedge clk);
      #1;
      sfr_wr = 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      @(posedge clk);
      #1;
      sfr_rd = 1'b0;
      v      = sfr_rdata_r;
      @(posedge clk);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk_reg(v, exp);
   endtask

   // poll control reg until the go bit drops; bounded since write length varies
   task automatic poll_clear(input logic [7:0] mask, input logic [7:0] exp);
      logic [7:0] v;
      int         n;
      for (n = 0; n < 3000; n++) begin
         rd(8'h40, v);
         if ((v & mask) === 8'h00) break;
      end
      if (n == 3000) begin
         err_count++;
         $display("unexpected at %0t: go bit never cleared", $time);
      end
      chk_reg(v, exp);
   endtask

   task automatic do_write(input logic [4:0] a, input logic [7:0] d, input logic [7:0] en);
      wr(8'h04, 8'h00);
      wr(8'h0a, {3'h0, a});
      wr(8'h0b, d);
      wr(8'h0c, en & 8'h06);
      wr(8'h04, 8'h01);
      wr(8'h40, 8'h08);
      wr(8'h40, 8'h0c);
      rd_chk(8'h40, 8'h0c);
      wr(8'h04, 8'h00);
      wr(8'h0c, en);
      wr(8'h04, 8'h01);
      poll_clear(8'h04, 8'h08);
      wr(8'h04, 8'h00);
      rd_chk(8'h0c, 8'h18 | en);
      chk_irq(irq_req_r, en == 8'h07);
      if (en == 8'h07) begin
         irq_ack = 1'b1;
         @(posedge clk);
         #1;
         irq_ack = 1'b0;
         @(posedge clk);
         #1;
         rd_chk(8'h0c, 8'h10 | en);
         chk_irq(irq_req_r, 1'b0);
         wr(8'h0c, en);
         rd_chk(8'h0c, en);
      end
   endtask

   task automatic do_read(input logic [4:0] a);
      wr(8'h04, 8'h00);
      wr(8'h0a, {3'h0, a});
      // control reached through the pointer, as software does
      wr(8'h03, 8'h40);
      wr(8'h04, 8'h01);
      wr(8'h02, 8'h02);
      wr(8'h02, 8'h03);
      rd_chk(8'h02, 8'h03);
      poll_clear(8'h01, 8'h02);
      wr(8'h04, 8'h00);
      rd_chk(8'h0b, 8'(mem[a]));
      rd_chk(8'h0b, 8'(mem[a]));
   endtask

   initial begin
      #400000;
      err_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_sim();
   end

   initial begin
      logic [4:0] a;
      logic [7:0] d;
      rst        = 1'b1;
      sfr_addr   = 8'h00;
      sfr_wr     = 1'b0;
      sfr_rd     = 1'b0;
      sfr_wdata  = 8'h00;
      irq_ack    = 1'b0;
      err_count  = 0;
      num_checks = 0;
      void'($urandom(32'h6c06));
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      @(posedge clk);
      #1;
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h0c, 8'h00);
      chk_irq(irq_req_r, 1'b0);
      wr(8'h04, 8'h01);
      rd_chk(8'h40, 8'h00);
      wr(8'h40, 8'h04);
      rd_chk(8'h40, 8'h00);
      wr(8'h40, 8'h01);
      rd_chk(8'h40, 8'h00);
      rd_chk(8'h3f, 8'h00);
      $display("test reset values and refused starts done");
      // every enable combination, ends of the address range first
      for (int i = 0; i < 8; i++) begin
         a = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
         d = 8'($urandom);
         do_write(a, d, 8'(i));
         mem[a] = d;
         a_q.push_back(a);
      end
      $display("test writes and interrupt flags done");
      // reset with program allow and bank 1 set; cells must survive it
      wr(8'h04, 8'h01);
      wr(8'h40, 8'h08);
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      @(posedge clk);
      #1;
      rd_chk(8'h04, 8'h00);
      wr(8'h04, 8'h01);
      rd_chk(8'h40, 8'h00);
      $display("test power-on protection done");
      foreach (a_q[k]) do_read(5'(a_q[k]));
      $display("test read back done");
      end_sim();
   end
endmodule
